// >>> rtl/ssp_core.v
/*
  Synchronous serial port: master or slave on SPI, frame-sync
  or three-wire buses, with transmit and receive FIFOs.
  Assumes all pins arrive asynchronously and are synchronised
  here; configuration ports stay stable while a frame runs.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ssp_defs.vh"
module ssp_core
(
  // Clock, reset and reset release
  input wire sys_clk,
  input wire rst_b,
  input wire port_reset_release_bit,
  // Configuration
  input wire cfg_master,
  input wire [1:0] cfg_format,
  input wire cfg_cpol,
  input wire cfg_cpha,
  input wire [3:0] frame_size_field,
  input wire [7:0] clk_half_div,
  // FIFO data port
  input wire tx_wr_en,
  input wire [15:0] tx_wr_data,
  output wire tx_full,
  input wire rx_rd_en,
  output wire [15:0] rx_rd_data,
  output wire rx_empty,
  // Status
  output reg busy_r,
  // Serial clock pin
  input wire sck_i,
  output reg sck_r,
  output reg sck_oe_b_r,
  // Select or frame-sync pin
  input wire frame_sync_line_i,
  output reg sel_r,
  output reg sel_oe_b_r,
  // Master-in slave-out pin
  input wire miso_i,
  output reg miso_o_r,
  output reg miso_oe_b_r,
  // Master-out slave-in pin
  input wire mosi_i,
  output reg mosi_o_r,
  output reg mosi_oe_b_r
);

  // Block runs only while both resets are released
  wire run; // Combined reset, high when running
  assign run = rst_b & port_reset_release_bit;

  // Two-flop synchronisers for every pin input
  reg sck_m_r, sck_s_r, sck_q_r; // Clock meta, sync, previous
  reg sel_m_r, sel_s_r; // Select meta, sync
  reg miso_m_r, miso_s_r; // MISO meta, sync
  reg mosi_m_r, mosi_s_r; // MOSI meta, sync

  always @(posedge sys_clk)
  begin
    if (!run)
    begin
      sck_m_r <= 1'b0;
      sck_s_r <= 1'b0;
      sck_q_r <= 1'b0;
      sel_m_r <= 1'b1; // Idle high, so no false select after reset
      sel_s_r <= 1'b1;
      miso_m_r <= 1'b0;
      miso_s_r <= 1'b0;
      mosi_m_r <= 1'b0;
      mosi_s_r <= 1'b0;
    end
    else
    begin
      sck_m_r <= sck_i;
      sck_s_r <= sck_m_r;
      sck_q_r <= sck_s_r;
      sel_m_r <= frame_sync_line_i;
      sel_s_r <= sel_m_r;
      miso_m_r <= miso_i;
      miso_s_r <= miso_m_r;
      mosi_m_r <= mosi_i;
      mosi_s_r <= mosi_m_r;
    end
  end

  // Format decode
  wire fmt_ssi; // Frame-sync format
  wire pol; // Clock idle level
  wire pha; // Sample on trailing edge
  wire act_hi; // Select active level
  assign fmt_ssi = (cfg_format == `SSP_FMT_SSI);
  assign pol = (cfg_format == `SSP_FMT_SPI) ? cfg_cpol : 1'b0;
  assign pha = (cfg_format == `SSP_FMT_SPI) ? cfg_cpha : fmt_ssi;
  assign act_hi = fmt_ssi;

  // Frame length; unsupported codes fall back to four bits
  wire [4:0] len; // Bits per frame
  wire [5:0] last_e; // Index of final clock edge
  wire [4:0] pad; // Left shift to put the MSB at bit 15
  assign len = (frame_size_field < `SSP_FSZ_MIN) ? `SSP_LEN_MIN
             : ({1'b0, frame_size_field} + `SSP_LEN_ONE);
  assign last_e = {len, 1'b0} - 6'h01;
  assign pad = 5'h10 - len;

  // Received word with bits above the frame masked off
  wire [15:0] len_mask; // Ones in the low len bits
  assign len_mask = 16'hffff >> pad;

  // Sequencer registers
  reg [2:0] st_r; // Sequencer state
  reg [7:0] div_r; // Half-period down counter
  reg [5:0] ecnt_r; // Clock edge index in frame
  reg [15:0] tx_sh_r; // Outgoing bits, MSB first at bit 15
  reg [15:0] rx_sh_r; // Incoming bits, enter at bit 0
  reg dout_r; // Bit on the data output
  reg pop_r; // Transmit word was popped for this frame
  reg push_r; // Store received word this cycle

  // Half period in system clocks, never below one
  wire [7:0] half_m1; // Reload value of divider
  assign half_m1 = (clk_half_div == 8'h00) ? 8'h00 : (clk_half_div - 8'h01);

  // Slave select qualification
  wire sel_act; // Synchronised select at its active level
  wire sck_edge; // Any edge of external clock
  wire sck_trail; // External clock returning to idle
  assign sel_act = (sel_s_r == act_hi);
  assign sck_edge = sck_s_r ^ sck_q_r;
  assign sck_trail = sck_edge & (sck_s_r == pol);

  // Frame start conditions
  wire slv_start; // Slave sees the start of a frame
  wire m_start; // Master has work queued
  wire start; // Frame begins this cycle
  wire tx_empty; // Transmit FIFO empty
  assign slv_start = fmt_ssi ? (sck_trail & sel_s_r)
                   : sel_act;
  assign m_start = ~tx_empty;
  assign start = (st_r == `SSP_ST_IDLE) & (cfg_master ? m_start : slv_start);

  // Transmit pop at frame start; slave sends zeros if empty
  wire tx_pop; // One-cycle pop request
  assign tx_pop = start & ~tx_empty;

  // Edge event: master divider or slave clock edge
  wire edge_now; // A clock edge to act on
  assign edge_now = (st_r == `SSP_ST_RUN)
                  & (cfg_master ? (div_r == 8'h00) : sck_edge);

  // Edge roles; leading edges have even index
  wire lead; // Edge leaves idle level
  wire pre; // Frame-sync pulse edge, carries no data
  wire samp; // Sample the input on this edge
  wire shft; // Advance the output on this edge
  assign lead = ~ecnt_r[0];
  assign pre = (ecnt_r >= `SSP_ECNT_PRE);
  assign samp = edge_now & ~pre & (pha ? ~lead : lead);
  assign shft = edge_now & ~pre & (pha ? lead : ~lead);

  // Input bit: master reads MISO, slave reads MOSI
  wire din; // Selected serial input
  assign din = cfg_master ? miso_s_r : mosi_s_r;

  // Last edge of the frame
  wire fin; // Final edge taken now
  assign fin = edge_now & (ecnt_r == last_e);

  // Loaded transmit word, left-justified
  wire [15:0] tx_word; // Word for this frame
  wire [15:0] tx_fifo_data; // Popped transmit word
  wire [15:0] tx_just; // Word moved to the top bits
  assign tx_word = pop_r ? tx_fifo_data : 16'h0000;
  assign tx_just = tx_word << pad;

  // Sequencer and shifters
  always @(posedge sys_clk)
  begin
    if (!run)
    begin
      st_r <= `SSP_ST_IDLE;
      div_r <= 8'h00;
      ecnt_r <= `SSP_ECNT_ZERO;
      tx_sh_r <= 16'h0000;
      rx_sh_r <= 16'h0000;
      dout_r <= 1'b0;
      pop_r <= 1'b0;
      push_r <= 1'b0;
      sck_r <= 1'b0;
      sel_r <= 1'b1;
    end
    else
    begin
      push_r <= 1'b0;
      case (st_r)
        `SSP_ST_IDLE:
        begin
          // Clock parked at idle level, select inactive
          sck_r <= pol;
          sel_r <= ~act_hi;
          pop_r <= tx_pop;
          if (start)
          begin
            st_r <= `SSP_ST_FETCH;
          end
        end
        `SSP_ST_FETCH:
        begin
          // Popped word is now on the FIFO read register
          tx_sh_r <= tx_just;
          dout_r <= tx_just[15]; // First bit ready before any edge
          rx_sh_r <= 16'h0000;
          div_r <= half_m1;
          // Frame-sync master emits one sync clock first
          ecnt_r <= (cfg_master & fmt_ssi) ? `SSP_ECNT_PRE : `SSP_ECNT_ZERO;
          if (cfg_master)
          begin
            sel_r <= act_hi;
            st_r <= `SSP_ST_SETUP;
          end
          else
          begin
            st_r <= `SSP_ST_RUN;
          end
        end
        `SSP_ST_SETUP:
        begin
          // Select leads the first clock edge by a full period
          if (div_r == 8'h00)
          begin
            div_r <= half_m1;
            st_r <= `SSP_ST_RUN;
          end
          else
          begin
            div_r <= div_r - 8'h01;
          end
        end
        `SSP_ST_RUN:
        begin
          // Master divider paces the edges
          if (cfg_master)
          begin
            div_r <= (div_r == 8'h00) ? half_m1 : (div_r - 8'h01);
          end
          if (edge_now)
          begin
            ecnt_r <= ecnt_r + 6'h01;
            if (cfg_master)
            begin
              sck_r <= ~sck_r;
              // Sync pulse ends as the first data bit starts
              if (fmt_ssi & (ecnt_r == `SSP_ECNT_LAST_PRE))
              begin
                sel_r <= ~act_hi;
              end
            end
          end
          // Input is sampled and output advanced on opposite clock edges
          if (samp)
          begin
            rx_sh_r <= {rx_sh_r[14:0], din};
          end
          if (shft)
          begin
            // Trailing-phase mode shows its first bit on edge zero
            if (pha & (ecnt_r == `SSP_ECNT_ZERO))
            begin
              dout_r <= tx_sh_r[15];
            end
            else
            begin
              tx_sh_r <= {tx_sh_r[14:0], 1'b0};
              dout_r <= tx_sh_r[14];
            end
          end
          if (fin)
          begin
            push_r <= 1'b1;
            st_r <= cfg_master ? `SSP_ST_HOLD : `SSP_ST_IDLE;
          end
          else if (~cfg_master & ~fmt_ssi & ~sel_act)
          begin
            // Deselect mid-frame: partial frame is dropped
            st_r <= `SSP_ST_IDLE;
          end
        end
        `SSP_ST_HOLD:
        begin
          // Select held a half period past the last edge
          if (div_r == 8'h00)
          begin
            sel_r <= ~act_hi;
            st_r <= `SSP_ST_IDLE;
          end
          else
          begin
            div_r <= div_r - 8'h01;
          end
        end
        default:
        begin
          st_r <= `SSP_ST_IDLE;
        end
      endcase
    end
  end

  // Pin drivers; enables are low while driving
  always @(posedge sys_clk)
  begin
    if (!run)
    begin
      sck_oe_b_r <= 1'b1;
      sel_oe_b_r <= 1'b1;
      miso_o_r <= 1'b0;
      miso_oe_b_r <= 1'b1;
      mosi_o_r <= 1'b0;
      mosi_oe_b_r <= 1'b1;
      busy_r <= 1'b0;
    end
    else
    begin
      // Master owns clock, select and MOSI
      sck_oe_b_r <= ~cfg_master;
      sel_oe_b_r <= ~cfg_master;
      mosi_oe_b_r <= ~cfg_master;
      mosi_o_r <= dout_r;
      // Slave drives MISO only while selected; a frame-sync slave drives it while a frame runs
      miso_oe_b_r <= cfg_master | ~(fmt_ssi ? (st_r != `SSP_ST_IDLE) : sel_act);
      miso_o_r <= dout_r;
      busy_r <= (st_r != `SSP_ST_IDLE);
    end
  end

  // Transmit FIFO: software writes push frames
  ssp_fifo #(
    .WIDTH(`SSP_WIDTH),
    .DEPTH(`SSP_DEPTH),
    .AW(`SSP_AW)
  ) u_tx_fifo (
    .sys_clk(sys_clk),
    .rst_b(run),
    .wr_en(tx_wr_en),
    .wr_data(tx_wr_data),
    .full(tx_full),
    .rd_en(tx_pop),
    .rd_data(tx_fifo_data),
    .empty(tx_empty)
  );

  // Receive FIFO: completed frames land here; overflow drops
  ssp_fifo #(
    .WIDTH(`SSP_WIDTH),
    .DEPTH(`SSP_DEPTH),
    .AW(`SSP_AW)
  ) u_rx_fifo (
    .sys_clk(sys_clk),
    .rst_b(run),
    .wr_en(push_r),
    .wr_data(rx_sh_r & len_mask),
    .full(),
    .rd_en(rx_rd_en),
    .rd_data(rx_rd_data),
    .empty(rx_empty)
  );

endmodule
`default_nettype wire

// >>> rtl/ssp_defs.vh
/*
  Constants for the synchronous serial port: formats, states,
  frame sizes and FIFO shape.
  Assumes inclusion by bare name from the design files.
*/
`ifndef SSP_DEFS_VH
`define SSP_DEFS_VH

// Frame and FIFO shape
`define SSP_WIDTH 16
`define SSP_DEPTH 8
`define SSP_AW 3

// Bus formats
`define SSP_FMT_SPI 2'h0
`define SSP_FMT_SSI 2'h1
`define SSP_FMT_3W 2'h2

// Frame size field limits
`define SSP_FSZ_MIN 4'h3
`define SSP_LEN_MIN 5'h04
`define SSP_LEN_ONE 5'h01

// Edge counter: two pre edges carry the frame-sync pulse
`define SSP_ECNT_PRE 6'h3e
`define SSP_ECNT_LAST_PRE 6'h3f
`define SSP_ECNT_ZERO 6'h00

// Sequencer states for master and slave
`define SSP_ST_IDLE 3'h0
`define SSP_ST_FETCH 3'h1
`define SSP_ST_SETUP 3'h2
`define SSP_ST_RUN 3'h3
`define SSP_ST_HOLD 3'h4

`endif

// >>> rtl/ssp_fifo.v
/*
  Small synchronous FIFO with registered flags and registered
  read data (data appears the cycle after a pop).
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
module ssp_fifo
#(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3
)
(
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // Fill side
  input wire wr_en,
  input wire [WIDTH-1:0] wr_data,
  output reg full,
  // Drain side
  input wire rd_en,
  output reg [WIDTH-1:0] rd_data,
  output reg empty
);

  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Frame storage
  reg [AW-1:0] wr_ptr_r; // Next slot to write
  reg [AW-1:0] rd_ptr_r; // Oldest slot
  reg [AW:0] count_r; // Frames held
  reg [AW:0] count_nxt;
  wire push; // Accepted write
  wire pop; // Accepted read

  // Writes to a full FIFO and reads of an empty one are dropped
  assign push = wr_en & ~full;
  assign pop = rd_en & ~empty;

  // Occupancy after this cycle
  always @*
  begin
    count_nxt = count_r;
    if (push & ~pop)
    begin
      count_nxt = count_r + 1'b1;
    end
    else if (pop & ~push)
    begin
      count_nxt = count_r - 1'b1;
    end
  end

  // Storage has no reset; only the pointers matter
  always @(posedge sys_clk)
  begin
    if (push)
    begin
      mem[wr_ptr_r] <= wr_data;
    end
  end

  // Pointers, flags and read register
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
      full <= 1'b0;
      empty <= 1'b1;
      rd_data <= {WIDTH{1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
        rd_data <= mem[rd_ptr_r];
      end
      count_r <= count_nxt;
      full <= (count_nxt == DEPTH[AW:0]);
      empty <= (count_nxt == {(AW+1){1'b0}});
    end
  end

endmodule
`default_nettype wire

// >>> test/ssp_core_assertions.sv
/*
  Checker for the serial port core: pin enables, idle levels and
  frame length. Assumes binding onto the core's own ports.
*/
`timescale 1ns/1ns
`default_nettype none
module ssp_chk (
  // Clock and resets
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic port_reset_release_bit,
  // Configuration
  input wire logic cfg_master,
  input wire logic [1:0] cfg_format,
  input wire logic cfg_cpol,
  input wire logic [3:0] frame_size_field,
  // FIFO port
  input wire logic tx_wr_en,
  input wire logic tx_full,
  input wire logic rx_rd_en,
  input wire logic rx_empty,
  input wire logic [15:0] rx_rd_data,
  input wire logic busy_r,
  // Pins
  input wire logic sck_r,
  input wire logic sck_oe_b_r,
  input wire logic sel_r,
  input wire logic sel_oe_b_r,
  input wire logic frame_sync_line_i,
  input wire logic miso_oe_b_r,
  input wire logic mosi_oe_b_r
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b || !port_reset_release_bit);
  logic sck_d_r;  // Clock pin one cycle ago
  logic [5:0] edge_cnt_r;  // Clock edges seen in this frame
  logic [5:0] exp_edges;  // Edges a whole frame must carry
  // Short size codes behave as four bits; sync pulse adds two edges
  assign exp_edges = ((frame_size_field < 4'h3) ? 6'h08 : {1'b0, frame_size_field, 1'b0} + 6'h02)
    + ((cfg_format == 2'h1) ? 6'h02 : 6'h00);
  // Count clock toggles while a frame is busy
  always @(posedge sys_clk)
  begin
    sck_d_r <= sck_r;
    if (!busy_r)
      edge_cnt_r <= 6'h00;
    else if (sck_r != sck_d_r)
      edge_cnt_r <= edge_cnt_r + 6'h01;
  end
  sequence idle_s;
    cfg_master && !busy_r && $stable(cfg_cpol) && $stable(cfg_format);
  endsequence
  sequence unsel_s;
    !cfg_master && cfg_format != 2'h1 && frame_sync_line_i;
  endsequence
  reset_quiet_a: assert property (disable iff (1'b0)
    (!rst_b || !port_reset_release_bit) |=> sck_oe_b_r && sel_oe_b_r && miso_oe_b_r
      && mosi_oe_b_r && !busy_r && rx_empty && !tx_full) else $error("outputs active in reset");
  idle_clock_a: assert property (idle_s [*3] |-> sck_r == (cfg_format == 2'h0 && cfg_cpol))
    else $error("clock not at idle level");
  idle_select_a: assert property (idle_s [*3] |-> sel_r == (cfg_format != 2'h1))
    else $error("select not inactive between frames");
  select_frame_a: assert property (cfg_master && cfg_format != 2'h1 && busy_r && $changed(sck_r)
    |-> !sel_r) else $error("clock moved without select");
  miso_float_a: assert property (unsel_s [*4] |-> miso_oe_b_r)
    else $error("unselected slave drives data out");
  master_pins_a: assert property (cfg_master [*2] |-> miso_oe_b_r && !mosi_oe_b_r
    && !sck_oe_b_r && !sel_oe_b_r) else $error("master pin enables wrong");
  slave_pins_a: assert property (!cfg_master [*2] |-> mosi_oe_b_r && sck_oe_b_r && sel_oe_b_r)
    else $error("slave drives a master pin");
  frame_start_a: assert property (cfg_master && !busy_r && tx_wr_en && !tx_full |-> ##[1:4] busy_r)
    else $error("frame did not start");
  frame_len_a: assert property ($fell(busy_r) && cfg_master |-> edge_cnt_r == exp_edges)
    else $error("wrong clock edge count");
  empty_read_a: assert property (rx_empty && rx_rd_en |=> $stable(rx_rd_data))
    else $error("read of empty FIFO changed data");
endmodule
bind ssp_core ssp_chk i_ssp_chk (.sys_clk, .rst_b, .port_reset_release_bit, .cfg_master, .cfg_format,
  .cfg_cpol, .frame_size_field, .tx_wr_en, .tx_full, .rx_rd_en, .rx_empty, .rx_rd_data, .busy_r,
  .sck_r, .sck_oe_b_r, .sel_r, .sel_oe_b_r, .frame_sync_line_i, .miso_oe_b_r, .mosi_oe_b_r);
`default_nettype wire

// >>> test/ssp_peer.sv
/*
  Behavioural slave for clock modes 0 and 3, MSB first, word
  left-aligned in tx_w. Assumes select active low, rising-edge sampling.
*/
`timescale 1ns/1ns
`default_nettype none
module ssp_peer (
  // Pins
  input wire logic sck,
  input wire logic sel_b,
  input wire logic mosi,
  output logic miso = 1'b0,
  // Words
  input wire logic [15:0] tx_w,
  output logic [15:0] rx_w = 16'h0000
);
  logic [15:0] sh_r;  // Outgoing shift register
  logic seen_r = 1'b0;  // A rising edge has passed in this frame
  // Load on select; first bit must lead the first edge
  always @(negedge sel_b)
  begin
    sh_r = tx_w;
    rx_w = 16'h0000;
    seen_r = 1'b0;
    miso = tx_w[15];
  end
  // Sample on the rising edge of the master's clock
  always @(posedge sck)
    if (!sel_b)
    begin
      rx_w = {rx_w[14:0], mosi};
      seen_r = 1'b1;
    end
  // Change on the falling edge; an idle-high clock's first fall carries nothing
  always @(negedge sck)
    if (!sel_b && seen_r)
    begin
      sh_r = sh_r << 1;
      miso = sh_r[15];
    end
  // Released line does not keep its last value
  always @(posedge sel_b)
    miso = ~miso;
endmodule
`default_nettype wire

// >>> test/tb_sync_serial_port.sv
/*
  Self-checking bench for the serial port core.
  Assumes the mode 0 and 3 peer on the pins and a 125 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_sync_serial_port;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic rel = 1'b0;  // Reset release bit
  logic master = 1'b1;
  logic [1:0] fmt = 2'h0;
  logic cpol = 1'b0;
  logic cpha = 1'b0;  // SPI sampling phase
  logic [3:0] fsz = 4'h7;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [15:0] wr_data = 16'h0000;
  logic [15:0] peer_tx = 16'h0000;
  logic tb_sck = 1'b0;  // Still outside frames
  logic tb_sel = 1'b1;
  logic tb_mosi = 1'b0;
  logic [15:0] rd_data, peer_rx, got, mask, w, p;
  logic tx_full, rx_empty, busy_r, sck_r, sck_oe_b, sel_r, sel_oe_b;
  logic miso_o, miso_oe_b, mosi_o, mosi_oe_b, peer_miso;
  // Pin levels from whoever enables
  wire logic sck_w = sck_oe_b ? tb_sck : sck_r;
  wire logic sel_w = sel_oe_b ? tb_sel : sel_r;
  wire logic miso_w = miso_oe_b ? peer_miso : miso_o;
  wire logic mosi_w = mosi_oe_b ? tb_mosi : mosi_o;
  int failures = 0;
  int compares = 0;
  always #4 sys_clk = ~sys_clk;
  ssp_core i_ssp_core (.sys_clk(sys_clk), .rst_b(rst_b), .port_reset_release_bit(rel),
    .cfg_master(master), .cfg_format(fmt), .cfg_cpol(cpol), .cfg_cpha(cpha),
    .frame_size_field(fsz), .clk_half_div(8'h08), .tx_wr_en(wr_en), .tx_wr_data(wr_data),
    .tx_full(tx_full), .rx_rd_en(rd_en), .rx_rd_data(rd_data), .rx_empty(rx_empty),
    .busy_r(busy_r), .sck_i(sck_w), .sck_r(sck_r), .sck_oe_b_r(sck_oe_b),
    .frame_sync_line_i(sel_w), .sel_r(sel_r), .sel_oe_b_r(sel_oe_b), .miso_i(miso_w),
    .miso_o_r(miso_o), .miso_oe_b_r(miso_oe_b), .mosi_i(mosi_w), .mosi_o_r(mosi_o),
    .mosi_oe_b_r(mosi_oe_b));
  ssp_peer i_ssp_peer (.sck(sck_w), .sel_b(sel_w), .mosi(mosi_w), .miso(peer_miso),
    .tx_w(peer_tx), .rx_w(peer_rx));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Spaced two cycles so a strobe never flips twice at once
  task automatic wr(input logic [15:0] d);
    wr_en = 1'b1;
    wr_data = d;
    tick(1);
    wr_en = 1'b0;
    tick(1);
  endtask
  task automatic rd;
    rd_en = 1'b1;
    tick(1);
    rd_en = 1'b0;
    tick(1);
    got = rd_data;
  endtask
  // Idle means twenty quiet cycles, so back-to-back frames count as one
  task automatic wait_idle;
    int idle;
    int n;
    idle = 0;
    n = 0;
    while (idle < 20 && n < 5000)
    begin
      tick(1);
      idle = (busy_r === 1'b0) ? idle + 1 : 0;
      n++;
    end
    if (n == 5000)
      check(busy_r, 16'h0000);
  endtask
  // One 80 ns bit as external master, sampling on the rise
  task automatic sbit(input logic b);
    tb_mosi = b;
    tick(5);
    tb_sck = 1'b1;
    got = {got[14:0], miso_w};
    tick(5);
    tb_sck = 1'b0;
  endtask
  task automatic finish_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog well past the expected run
  initial
  begin
    #400000;
    failures++;
    finish_test;
  end
  initial
  begin
    tick(2);
    rst_b = 1'b1;
    wr(16'h00a5);
    tick(20);
    check(busy_r, 16'h0000);
    check(sck_oe_b, 16'h0001);
    rel = 1'b1;
    tick(20);
    check(busy_r, 16'h0000);
    // Sizes 4, 12 and 16 in SPI then three-wire
    for (int k = 0; k < 6; k++)
    begin
      fmt = (k < 3) ? 2'h0 : 2'h2;
      fsz = (k % 3 == 0) ? 4'h3 : ((k % 3 == 1) ? 4'hb : 4'hf);
      mask = 16'hffff >> (4'hf - fsz);
      w = 16'h9c3a ^ k[15:0];
      p = 16'h5ac3 + k[15:0];
      peer_tx = p << (4'hf - fsz);
      wr(w);
      wait_idle;
      check(peer_rx, w & mask);
      rd;
      check(got, p & mask);
      check(rx_empty, 16'h0001);
    end
    // Back-to-back frames
    fmt = 2'h0;
    fsz = 4'h7;
    peer_tx = 16'h3c00;
    wr(16'h0012);
    wr(16'h0034);
    wait_idle;
    check(peer_rx, 16'h0034);
    rd;
    check(got, 16'h003c);
    rd;
    check(got, 16'h003c);
    // Idle levels per format
    cpol = 1'b1;
    tick(5);
    check(sck_r, 16'h0001);
    // Mode 3: change on the falling lead, sample on the rise
    cpha = 1'b1;
    peer_tx = 16'ha500;
    wr(16'h005a);
    wait_idle;
    check(peer_rx, 16'h005a);
    rd;
    check(got, 16'h00a5);
    cpha = 1'b0;
    fmt = 2'h1;
    tick(5);
    check(sck_r, 16'h0000);
    check(sel_r, 16'h0000);
    wr(16'h00ff);
    wait_idle;
    check(rx_empty, 16'h0000);
    rd;
    fmt = 2'h0;
    cpol = 1'b0;
    tick(5);
    check(sel_r, 16'h0001);
    // Slave: fill until refused, then one frame from outside
    master = 1'b0;
    tick(4);
    for (int k = 0; k < 9; k++)
      wr(16'h00c0 + k[15:0]);
    check(tx_full, 16'h0001);
    check(miso_oe_b, 16'h0001);
    tb_sel = 1'b0;
    tick(5);
    check(miso_oe_b, 16'h0000);
    got = 16'h0000;
    for (int b = 7; b >= 0; b--)
      sbit(p[b] ^ 1'b1 ^ 8'h96 >> b);
    tb_mosi = ~tb_mosi;
    tick(5);
    tb_sel = 1'b1;
    tick(5);
    check(got, 16'h00c0);
    w = {8'h00, ~p[7:0] ^ 8'h96};
    rd;
    check(got, w);
    check(tx_full, 16'h0000);
    // Clocks without select carry nothing
    for (int b = 0; b < 8; b++)
      sbit(1'b1);
    tick(10);
    check(rx_empty, 16'h0001);
    // Read of an empty FIFO keeps the last word
    rd;
    check(got, w);
    finish_test;
  end
endmodule
`default_nettype wire
